// ---- line_status_pkg.sv ----
// package for the line status and ring control block
// assumes a 125 MHz system clock and an APB register bus
package line_status_pkg;
    localparam logic [11:0] ADDR_RING_HOOK_CTRL = 12'h048;
    localparam logic [11:0] ADDR_LINE_STATUS    = 12'h04c;
    localparam logic [11:0] ADDR_HOOK_CTRL      = 12'h014;
    localparam logic [11:0] ADDR_IRQ_STATUS     = 12'h100;
    localparam logic [11:0] ADDR_IRQ_MASK       = 12'h104;
    localparam int          IDX_RING_HOOK_CTRL  = 18;
    localparam int          IDX_LINE_STATUS     = 19;
    localparam int          BIT_FULL_WAVE       = 1;
    localparam int          BIT_SQUELCH         = 0;
    localparam int          BIT_OFF_HOOK        = 0;
    localparam int          BIT_ONHOOK_MON      = 1;
    localparam int          BIT_FORCE_ONHOOK    = 2;
    localparam int          BIT_FAST_SETTLE     = 3;
    localparam int          BIT_POWERDOWN       = 4;
    localparam int          BIT_CTR21           = 5;
    localparam logic [7:0]  RESET_RING_HOOK     = 8'h00;
    localparam logic [7:0]  RESET_HOOK          = 8'h00;
    localparam logic [4:0]  CODE_ZERO           = 5'h00;
    localparam logic [4:0]  CODE_OVERLOAD       = 5'h1f;
    localparam logic [4:0]  CODE_MAX_NORMAL     = 5'h1e;
    localparam int          OVL_MA_NORMAL       = 140;
    localparam int          OVL_MA_CTR21        = 56;
    localparam int          MA_PER_STEP         = 3;
    localparam int          DROPOUT_FRAMES      = 16;
    localparam int          IRQ_BITS            = 4;
    typedef struct packed {
        logic [4:0] code;
        logic       overload;
        logic       dropout;
        logic       protect;
    } line_status_t;
endpackage

// ---- line_status_ring_control.sv ----
// top of the line status readout and ring detector control
// assumes pins from the line side are asynchronous, frame strobe from the serial port
// Summary of operation
// - force on-hook keeps off-hook counter running
// - sense code reads zero during ring
// - fast settle drives settling off-hook state
// - full-wave select steers ring rectifier
// - squelch enables fast ring offset recovery
// - sense code selected by hook state and ring
// - on-hook voltage code passes through
// - off-hook current code, 11111 overload
// - overload above 140 mA, 56 mA in CTR21
// - live overload self-clears when level drops
// - dropout clears sixteen frames after return
// - on-hook dropout equals not powerdown
// - protect flag follows protection active
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module line_status_ring_control (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // line side inputs
    input  wire logic [4:0]  LINE_VOLTAGE_CODE,
    input  wire logic [7:0]  LOOP_CURRENT_MA,
    input  wire logic        RING_ACTIVE,
    input  wire logic        RX_OVERLOAD,
    input  wire logic        LINE_SUPPLY_OK,
    input  wire logic        PROTECT_ACTIVE,
    input  wire logic        OFFHOOK_COUNT_DONE,
    input  wire logic        FRAME_TICK,
    // line side controls and interrupt request
    output logic             RING_FULL_WAVE_SEL,
    output logic             RING_SQUELCH,
    output logic             LINE_OFF_HOOK,
    output logic             FAST_SETTLE,
    output logic             OFFHOOK_COUNT_RUN,
    output logic             LINE_SIDE_POWERDOWN,
    output logic             ONHOOK_LINE_MONITOR,
    output logic             IRQ
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0] volt_s1, volt_s2;
    logic [7:0] cur_s1, cur_s2;
    logic [5:0] lv_s1, lv_s2;
    logic [7:0] ring_hook;
    logic [7:0] hook;
    logic [3:0] drop_cnt;
    logic       dropout;
    logic [4:0] code;
    logic       live_overload_flag;
    line_status_pkg::line_status_t stat;
    logic [line_status_pkg::IRQ_BITS-1:0] irq_stat, irq_mask, ev, prev_ev;
    logic       wr;
    logic       ring_s, ovl_s, supply_s, prot_s, cnt_done_s, frame_s;
    logic [7:0] ovl_limit;

    assign wr = PSEL && PENABLE && PWRITE;
    assign {ring_s, ovl_s, supply_s, prot_s, cnt_done_s, frame_s} = lv_s2;

    // two flop synchronisers for line side pins
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            volt_s1 <= 5'h00;
            volt_s2 <= 5'h00;
            cur_s1  <= 8'h00;
            cur_s2  <= 8'h00;
            lv_s1   <= 6'h00;
            lv_s2   <= 6'h00;
        end else begin
            volt_s1 <= LINE_VOLTAGE_CODE;
            volt_s2 <= volt_s1;
            cur_s1  <= LOOP_CURRENT_MA;
            cur_s2  <= cur_s1;
            lv_s1   <= {RING_ACTIVE, RX_OVERLOAD, LINE_SUPPLY_OK, PROTECT_ACTIVE,
                        OFFHOOK_COUNT_DONE, FRAME_TICK};
            lv_s2   <= lv_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers, status register has no write path
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ring_hook <= line_status_pkg::RESET_RING_HOOK;
            hook      <= line_status_pkg::RESET_HOOK;
        end else if (wr && PADDR == line_status_pkg::ADDR_RING_HOOK_CTRL) begin
            ring_hook <= PWDATA[7:0];
        end else if (wr && PADDR == line_status_pkg::ADDR_HOOK_CTRL) begin
            hook <= PWDATA[7:0];
        end
    end

    // line side control outputs
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            RING_FULL_WAVE_SEL  <= 1'b0;
            RING_SQUELCH        <= 1'b0;
            LINE_OFF_HOOK       <= 1'b0;
            FAST_SETTLE         <= 1'b0;
            OFFHOOK_COUNT_RUN   <= 1'b0;
            LINE_SIDE_POWERDOWN <= 1'b0;
            ONHOOK_LINE_MONITOR <= 1'b0;
        end else begin
            RING_FULL_WAVE_SEL  <= ring_hook[line_status_pkg::BIT_FULL_WAVE];
            RING_SQUELCH        <= ring_hook[line_status_pkg::BIT_SQUELCH];
            LINE_OFF_HOOK       <= (hook[line_status_pkg::BIT_OFF_HOOK] ||
                                    hook[line_status_pkg::BIT_FAST_SETTLE]) &&
                                   !hook[line_status_pkg::BIT_FORCE_ONHOOK];
            FAST_SETTLE         <= hook[line_status_pkg::BIT_FAST_SETTLE] &&
                                   !hook[line_status_pkg::BIT_FORCE_ONHOOK];
            OFFHOOK_COUNT_RUN   <= hook[line_status_pkg::BIT_OFF_HOOK] ||
                                   hook[line_status_pkg::BIT_FAST_SETTLE];
            LINE_SIDE_POWERDOWN <= hook[line_status_pkg::BIT_POWERDOWN];
            ONHOOK_LINE_MONITOR <= hook[line_status_pkg::BIT_ONHOOK_MON];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // dropout flag with sixteen frame recovery
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            drop_cnt <= 4'h0;
            dropout  <= 1'b0;
        end else if (!LINE_OFF_HOOK) begin
            drop_cnt <= 4'h0;
            dropout  <= !LINE_SIDE_POWERDOWN;
        end else if (!supply_s) begin
            drop_cnt <= 4'h0;
            dropout  <= 1'b1;
        end else if (dropout && frame_s) begin
            drop_cnt <= drop_cnt + 4'h1;
            if (drop_cnt == 4'(line_status_pkg::DROPOUT_FRAMES - 1)) begin
                dropout <= 1'b0;
            end
        end
    end

    // sense code selection
    assign ovl_limit = hook[line_status_pkg::BIT_CTR21] ? 8'(line_status_pkg::OVL_MA_CTR21)
                                                        : 8'(line_status_pkg::OVL_MA_NORMAL);
    always_comb begin
        code = volt_s2;
        if (LINE_OFF_HOOK) begin
            if (cur_s2 > ovl_limit) begin
                code = line_status_pkg::CODE_OVERLOAD;
            end else if (cur_s2 / 8'(line_status_pkg::MA_PER_STEP) >
                         8'(line_status_pkg::CODE_MAX_NORMAL)) begin
                code = line_status_pkg::CODE_MAX_NORMAL;
            end else begin
                code = 5'(cur_s2 / 8'(line_status_pkg::MA_PER_STEP));
            end
        end
        if (ring_s) begin
            code = line_status_pkg::CODE_ZERO;
        end
    end
    assign live_overload_flag = ovl_s && cnt_done_s;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            stat <= '0;
        end else begin
            stat.code     <= code;
            stat.overload <= live_overload_flag;
            stat.dropout  <= dropout;
            stat.protect  <= prot_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: rising edges of ring, overload, dropout, protect
    assign ev = {ring_s, stat.overload, stat.dropout, stat.protect};
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            prev_ev  <= '0;
            irq_stat <= '0;
            irq_mask <= '0;
            IRQ      <= 1'b0;
        end else begin
            prev_ev <= ev;
            if (wr && PADDR == line_status_pkg::ADDR_IRQ_STATUS) begin
                irq_stat <= (irq_stat & ~PWDATA[3:0]) | (ev & ~prev_ev);
            end else begin
                irq_stat <= irq_stat | (ev & ~prev_ev);
            end
            if (wr && PADDR == line_status_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= PWDATA[3:0];
            end
            IRQ <= |(irq_stat & irq_mask);
        end
    end

    // apb read data and ready, no wait states
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    line_status_pkg::ADDR_RING_HOOK_CTRL: PRDATA <= {24'h0, ring_hook};
                    line_status_pkg::ADDR_HOOK_CTRL:      PRDATA <= {24'h0, hook};
                    line_status_pkg::ADDR_LINE_STATUS:    PRDATA <= {24'h0, stat};
                    line_status_pkg::ADDR_IRQ_STATUS:     PRDATA <= {28'h0, irq_stat};
                    line_status_pkg::ADDR_IRQ_MASK:       PRDATA <= {28'h0, irq_mask};
                    default: begin
                        PRDATA  <= 32'h0000_0000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_supply_back;
        LINE_OFF_HOOK && supply_s && dropout;
    endsequence

    property p_ring_zero;
        @(posedge SYS_CLK) disable iff (RST) ring_s |=> stat.code == 5'h00;
    endproperty
    a_ring_zero: assert property (p_ring_zero) else $error("code not zero in ring");

    property p_force_onhook;
        @(posedge SYS_CLK) disable iff (RST)
        hook[line_status_pkg::BIT_FORCE_ONHOOK] && hook[line_status_pkg::BIT_OFF_HOOK]
        |=> !LINE_OFF_HOOK && OFFHOOK_COUNT_RUN;
    endproperty
    a_force_onhook: assert property (p_force_onhook) else $error("force on-hook wrong");

    property p_fast_settle;
        @(posedge SYS_CLK) disable iff (RST) FAST_SETTLE |-> LINE_OFF_HOOK;
    endproperty
    a_fast_settle: assert property (p_fast_settle) else $error("fast settle not off-hook");

    property p_full_wave;
        @(posedge SYS_CLK) disable iff (RST)
        RING_FULL_WAVE_SEL == $past(ring_hook[line_status_pkg::BIT_FULL_WAVE]);
    endproperty
    a_full_wave: assert property (p_full_wave) else $error("full wave select lag");

    property p_squelch;
        @(posedge SYS_CLK) disable iff (RST)
        $rose(ring_hook[line_status_pkg::BIT_SQUELCH]) |=> RING_SQUELCH;
    endproperty
    a_squelch: assert property (p_squelch) else $error("squelch not applied");

    property p_ovl_gate;
        @(posedge SYS_CLK) disable iff (RST) !cnt_done_s |=> !stat.overload;
    endproperty
    a_ovl_gate: assert property (p_ovl_gate) else $error("overload not gated");

    property p_onhook_drop;
        @(posedge SYS_CLK) disable iff (RST)
        !LINE_OFF_HOOK |=> dropout == !$past(LINE_SIDE_POWERDOWN);
    endproperty
    a_onhook_drop: assert property (p_onhook_drop) else $error("on-hook dropout wrong");

    property p_drop_hold;
        @(posedge SYS_CLK) disable iff (RST)
        s_supply_back and (drop_cnt == 4'h0 && !frame_s) |=> dropout;
    endproperty
    a_drop_hold: assert property (p_drop_hold) else $error("dropout cleared early");

    property p_protect;
        @(posedge SYS_CLK) disable iff (RST) stat.protect == $past(prot_s);
    endproperty
    a_protect: assert property (p_protect) else $error("protect flag mismatch");

    sequence s_supply_lost;
        LINE_OFF_HOOK && !supply_s;
    endsequence

    property p_drop_set;
        @(posedge SYS_CLK) disable iff (RST) s_supply_lost |=> dropout;
    endproperty
    a_drop_set: assert property (p_drop_set) else $error("dropout not set");

    property p_ovl_clear;
        @(posedge SYS_CLK) disable iff (RST) !ovl_s |=> !stat.overload;
    endproperty
    a_ovl_clear: assert property (p_ovl_clear) else $error("overload not cleared");

    property p_ovl_code;
        @(posedge SYS_CLK) disable iff (RST)
        LINE_OFF_HOOK && !ring_s && cur_s2 > ovl_limit
        |=> stat.code == line_status_pkg::CODE_OVERLOAD;
    endproperty
    a_ovl_code: assert property (p_ovl_code) else $error("overload code missing");

    property p_status_read;
        @(posedge SYS_CLK) disable iff (RST)
        PSEL && !PENABLE && PADDR == line_status_pkg::ADDR_LINE_STATUS
        |=> PRDATA == {24'h0, $past(stat)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read not live");
endmodule

// ---- line_side_model.sv ----
// line side model: sense levels, loop current, supply and frame ticks
// assumes the bench sets the levels and the block drives the hook outputs
`timescale 1ns/10ps
module line_side_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // levels from the bench: ring, overload, protect, counter done
    input  wire logic [7:0] ma,
    input  wire logic [4:0] volts,
    input  wire logic [3:0] flags,
    input  wire logic       supply,
    input  wire logic       tick_en,
    // block side
    input  wire logic       off_hook,
    output logic      [4:0] v_code,
    output logic      [7:0] i_ma,
    output logic      [3:0] lvl,
    output logic            sup_ok,
    output logic            tick,
    output int              ticks
);
    logic [2:0] phase;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        v_code <= rst ? 5'h00 : volts;
        i_ma   <= (rst || !off_hook) ? 8'h00 : ma;  // no loop current while on-hook
        lvl    <= rst ? 4'h0 : flags;
        sup_ok <= rst ? 1'b1 : supply;
    end
    // one cycle high per eight-cycle frame, only while enabled
    always_ff @(posedge clk) begin
        if (rst || !tick_en) begin
            phase <= 3'h0;
            tick  <= 1'b0;
            ticks <= 0;
        end else begin
            phase <= phase + 3'h1;
            tick  <= (phase == 3'h7);
            if (phase == 3'h7) begin
                ticks <= ticks + 1;
            end
        end
    end
endmodule

// ---- line_status_ring_control_tb.sv ----
// self-checking bench for the line status and ring control block
// assumes the line side model and the block's package are compiled first
`timescale 1ns/10ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module line_status_ring_control_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic        pready, pslverr, err, irq, off_hook, fw, sq, fast, run, pd, mon;
    logic [7:0]  ma = 8'h00, i_ma, hooks [4] = '{8'h01, 8'h0d, 8'h08, 8'h12};
    logic [4:0]  volts = 5'h00, v_code;
    logic [3:0]  flags = 4'h0, lvl;
    logic        supply = 1'b1, tick_en = 1'b0, sup_ok, tick;
    int          fail_count = 0, check_count = 0, ticks, i, hk, bnd [4] = '{140, 141, 56, 57};
    ////////////////////////////////////////////////////////////////////////////////
    always #4 sys_clk = ~sys_clk;
    line_status_ring_control dut (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LINE_VOLTAGE_CODE(v_code), .LOOP_CURRENT_MA(i_ma),
        .RING_ACTIVE(lvl[3]), .RX_OVERLOAD(lvl[2]), .LINE_SUPPLY_OK(sup_ok),
        .PROTECT_ACTIVE(lvl[1]), .OFFHOOK_COUNT_DONE(lvl[0]), .FRAME_TICK(tick),
        .RING_FULL_WAVE_SEL(fw), .RING_SQUELCH(sq), .LINE_OFF_HOOK(off_hook), .FAST_SETTLE(fast),
        .OFFHOOK_COUNT_RUN(run), .LINE_SIDE_POWERDOWN(pd), .ONHOOK_LINE_MONITOR(mon), .IRQ(irq));
    line_side_model far (.clk(sys_clk), .rst(rst), .ma(ma), .volts(volts), .flags(flags),
        .supply(supply), .tick_en(tick_en), .off_hook(off_hook), .v_code(v_code), .i_ma(i_ma),
        .lvl(lvl), .sup_ok(sup_ok), .tick(tick), .ticks(ticks));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            conclude();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic settle;
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic wait_ticks(input int k);
        int n;
        for (n = 0; n < 400 && ticks < k; n++) @(posedge sys_clk);
        if (n == 400) begin
            fail_count++;
            conclude();
        end else begin
            settle();
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // model of the status byte, dropout left out
    function automatic logic [7:0] model(input int h, input int c, input int v, input logic [3:0] f);
        int code;
        int lim;
        lim = h[5] ? line_status_pkg::OVL_MA_CTR21 : line_status_pkg::OVL_MA_NORMAL;
        if (f[3]) code = 0;
        else if (h[0] && !h[2]) code = (c > lim) ? 31 : (c / 3 > 30 ? 30 : c / 3);
        else code = v;
        return {code[4:0], f[2] & f[0], 1'b0, f[1]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = 32'h0043;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, line_status_pkg::ADDR_RING_HOOK_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        for (i = 0; i < 4; i++) begin
            apb(1'b1, line_status_pkg::ADDR_RING_HOOK_CTRL, i);
            apb(1'b0, line_status_pkg::ADDR_RING_HOOK_CTRL, 32'h0);
            `CHK("ctrl readback", i, rd)
            `CHK("full wave", i[1], fw)
            `CHK("squelch", i[0], sq)
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, line_status_pkg::ADDR_HOOK_CTRL, 32'h0);
            apb(1'b1, line_status_pkg::ADDR_HOOK_CTRL, {24'h0, hooks[i]});
            settle();
            `CHK("off hook", (hooks[i][0] | hooks[i][3]) & !hooks[i][2], off_hook)
            `CHK("count run", hooks[i][0] | hooks[i][3], run)
            `CHK("fast settle", hooks[i][3] & !hooks[i][2], fast)
            `CHK("powerdown", hooks[i][4], pd)
            `CHK("monitor", hooks[i][1], mon)
        end
        for (i = 0; i < 2; i++) begin
            apb(1'b1, line_status_pkg::ADDR_HOOK_CTRL, i ? 32'h10 : 32'h0);
            settle();
            apb(1'b0, line_status_pkg::ADDR_LINE_STATUS, 32'h0);
            `CHK("onhook dropout", !i[0], rd[1])
        end
        supply <= 1'b0;
        apb(1'b1, line_status_pkg::ADDR_HOOK_CTRL, 32'h1);
        settle();
        apb(1'b0, line_status_pkg::ADDR_LINE_STATUS, 32'h0);
        `CHK("dropout set", 1'b1, rd[1])
        supply <= 1'b1;
        tick_en <= 1'b1;
        for (i = 0; i < 2; i++) begin
            wait_ticks(i ? 17 : 14);
            apb(1'b0, line_status_pkg::ADDR_LINE_STATUS, 32'h0);
            `CHK("dropout hold", !i[0], rd[1])
        end
        tick_en <= 1'b0;
        for (i = 0; i < 24; i++) begin
            r = lfsr(r);
            hk = i < 4 ? (i < 2 ? 1 : 33) : (i % 3 == 0 ? 0 : (i % 3 == 1 ? 1 : 33));
            ma <= i < 4 ? bnd[i][7:0] : r[7:0];
            volts <= r[12:8];
            flags <= i < 4 ? 4'h1 : r[16:13];
            apb(1'b1, line_status_pkg::ADDR_HOOK_CTRL, hk);
            settle();
            apb(1'b0, line_status_pkg::ADDR_LINE_STATUS, 32'h0);
            `CHK("status", {24'h0, model(hk, int'(ma), int'(volts), flags)}, rd & 32'hfd)
        end
        apb(1'b1, line_status_pkg::ADDR_LINE_STATUS, 32'hff);
        apb(1'b0, line_status_pkg::ADDR_LINE_STATUS, 32'h0);
        `CHK("status write", {24'h0, model(hk, int'(ma), int'(volts), flags)}, rd & 32'hfd)
        apb(1'b0, 12'hffc, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        flags <= 4'h0;
        settle();
        apb(1'b1, line_status_pkg::ADDR_IRQ_STATUS, 32'hf);
        apb(1'b1, line_status_pkg::ADDR_IRQ_MASK, 32'h1);
        flags <= 4'h2;
        for (i = 0; i < 3; i++) begin
            if (i == 1) apb(1'b1, line_status_pkg::ADDR_IRQ_MASK, 32'h0);
            if (i == 2) apb(1'b1, line_status_pkg::ADDR_IRQ_STATUS, 32'h1);
            if (i == 2) apb(1'b1, line_status_pkg::ADDR_IRQ_MASK, 32'h1);
            settle();
            apb(1'b0, line_status_pkg::ADDR_IRQ_STATUS, 32'h0);
            `CHK("irq status", i != 2, rd[0])
            `CHK("irq line", i == 0, irq)
        end
        conclude();
    end
endmodule
